// >>> design/replay_trig_pkg.sv
// ****************************************************************
// register map, codes and states of the replay trigger control
// ****************************************************************
package replay_trig_pkg;

   localparam int ADDR_W = 18;
   localparam int IDX_W  = 16;

   // register indices; the byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_COMMAND = 16'h0000;
   localparam logic [IDX_W-1:0] IDX_MODE    = 16'h9c40;
   localparam logic [IDX_W-1:0] IDX_DIR     = 16'h9ca4;
   localparam logic [IDX_W-1:0] IDX_TERM    = 16'h9cae;
   localparam logic [IDX_W-1:0] IDX_STATUS  = 16'h9cb8;
   localparam logic [IDX_W-1:0] IDX_COUNT   = 16'h9cb9;

   // trigger mode codes
   localparam logic [31:0] MODE_FREE_RUN = 32'h0000_0000;
   localparam logic [31:0] MODE_RISING   = 32'h0000_4e20;
   localparam logic [31:0] MODE_FALLING  = 32'h0000_4e2a;
   localparam logic [31:0] MODE_EITHER   = 32'h0000_4e3e;

   // board command codes
   localparam logic [31:0] CMD_START = 32'h0000_0004;
   localparam logic [31:0] CMD_FORCE = 32'h0000_0010;
   localparam logic [31:0] CMD_STOP  = 32'h0000_0040;

   // connector direction codes
   localparam logic [31:0] DIR_UNUSED = 32'h0000_0000;
   localparam logic [31:0] DIR_OUTPUT = 32'h0000_0001;

   // reset values
   localparam logic [31:0] RST_MODE = MODE_FREE_RUN;
   localparam logic [31:0] RST_DIR  = DIR_UNUSED;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // status register fields
   localparam int ST_BIT_IDLE   = 0;
   localparam int ST_BIT_ARMED  = 1;
   localparam int ST_BIT_REPLAY = 2;
   localparam int ST_BIT_EXT    = 3;
   localparam int ST_BIT_OE     = 4;
   localparam int ST_BIT_TERM   = 5;
   localparam int ST_BIT_LEVEL  = 6;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h1,
      ST_ARMED  = 3'h2,
      ST_REPLAY = 3'h4
   } trig_state_t;

endpackage : replay_trig_pkg

// >>> design/trig_links_if.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// edges seen on the synchronised trigger connector
// ****************************************************************
interface edge_event_if;
   logic rise;
   logic fall;
   logic level;
   modport source (output rise, output fall, output level);
   modport sink   (input rise, input fall, input level);
endinterface : edge_event_if

// ****************************************************************
// word access from the bus front end to the register file
// ****************************************************************
interface reg_access_if;
   logic        wrEn;
   logic [15:0] wrIdx;
   logic [31:0] wrData;
   logic [3:0]  wrStrb;
   logic        wrHit;
   logic [15:0] rdIdx;
   logic [31:0] rdData;
   logic        rdHit;
   modport front (output wrEn, output wrIdx, output wrData, output wrStrb,
                  output rdIdx, input wrHit, input rdData, input rdHit);
   modport regs  (input wrEn, input wrIdx, input wrData, input wrStrb,
                  input rdIdx, output wrHit, output rdData, output rdHit);
endinterface : reg_access_if

`default_nettype wire

// >>> design/trig_input_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// two-stage synchroniser and edge detector for the connector input
// ****************************************************************
module trig_input_sync
   import replay_trig_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   arst_n,
   input  wire logic   pinIn,
   edge_event_if.source ev
);

   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   // meta_ff feeds only sync_ff; edges compare the later stages
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= pinIn;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign ev.rise  = sync_ff & ~prev_ff;
   assign ev.fall  = ~sync_ff & prev_ff;
   assign ev.level = sync_ff;

endmodule : trig_input_sync

`default_nettype wire

// >>> design/axil_reg_front.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// axi4-lite slave front end, one write and one read at a time
// ****************************************************************
module axil_reg_front
   import replay_trig_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   reg_access_if.front            ra
);

   logic              awHeld_ff;
   logic [IDX_W-1:0]  awIdx_ff;
   logic              wHeld_ff;
   logic [31:0]       wData_ff;
   logic [3:0]        wStrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [31:0]       rdata_ff;
   logic [1:0]        rresp_ff;
   logic              doWrite;

   // address and data are taken in either order; one slot each
   assign awready = ~awHeld_ff;
   assign wready  = ~wHeld_ff;
   assign doWrite = awHeld_ff & wHeld_ff & ~bvalid_ff;

   assign ra.wrEn   = doWrite;
   assign ra.wrIdx  = awIdx_ff;
   assign ra.wrData = wData_ff;
   assign ra.wrStrb = wStrb_ff;
   assign ra.rdIdx  = araddr[ADDR_W-1:2];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_ff <= 1'b0;
         awIdx_ff  <= '0;
      end else if (awvalid && awready) begin
         awHeld_ff <= 1'b1;
         awIdx_ff  <= awaddr[ADDR_W-1:2];
      end else if (doWrite) begin
         awHeld_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wHeld_ff <= 1'b0;
         wData_ff <= RST_WORD;
         wStrb_ff <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld_ff <= 1'b1;
         wData_ff <= wdata;
         wStrb_ff <= wstrb;
      end else if (doWrite) begin
         wHeld_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= ra.wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // read data is captured at the address handshake, answer next cycle
   assign arready = ~rvalid_ff;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= RST_WORD;
         rresp_ff  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= ra.rdHit ? ra.rdData : RST_WORD;
         rresp_ff  <= ra.rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign bvalid = bvalid_ff;
   assign bresp  = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rdata  = rdata_ff;
   assign rresp  = rresp_ff;

endmodule : axil_reg_front

`default_nettype wire

// >>> design/replay_trigger_control.sv
// Overview of operation
// - free-run mode starts replay right after board start, no trigger needed.
// - force command triggers only while armed and waiting for a trigger.
// - direction zero leaves connector unused, output driver disabled.
// - direction one in internal mode drives connector with internal trigger events.
// - trigger output is high active and marks the start of replay.
// - external edge modes make the connector an input, direction ignored.
// - termination is enabled only while connector serves as trigger input.
// - rising-edge mode triggers on first low-to-high edge after start.
// - falling-edge mode triggers on first high-to-low edge after start.
// - either-edge mode triggers on rising and falling edges.
// - edges are ignored until replay ends and the device is re-armed.
// - one shared connector; incoming trigger is never passed on.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module replay_trigger_control
   import replay_trig_pkg::*;
#(
   parameter int COUNT_W = 16
)
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              trigPinIn,
   output logic                   trigPinOut,
   output logic                   trigPinOe,
   output logic                   termEnable,
   input  wire logic              replayDone,
   output logic                   replayStart,
   output logic                   boardRunning
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = oldVal;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = newVal[b*8 +: 8];
         end
      end
      return res;
   endfunction : mergeBytes

   function automatic logic isExtMode(input logic [31:0] mode);
      return (mode == MODE_RISING) || (mode == MODE_FALLING) || (mode == MODE_EITHER);
   endfunction : isExtMode

   function automatic logic isKnownIdx(input logic [IDX_W-1:0] idx);
      return (idx == IDX_COMMAND) || (idx == IDX_MODE) || (idx == IDX_DIR) ||
             (idx == IDX_TERM) || (idx == IDX_STATUS) || (idx == IDX_COUNT);
   endfunction : isKnownIdx

   // ****************************************************************
   // sub-blocks
   // ****************************************************************
   reg_access_if ra ();
   edge_event_if ev ();

   axil_reg_front u_front (
      .clk     (clk),
      .arst_n  (arst_n),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .ra      (ra.front)
   );

   trig_input_sync u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .pinIn  (trigPinIn),
      .ev     (ev.source)
   );

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [31:0]        command_ff;
   logic [31:0]        mode_ff;
   logic [31:0]        dir_ff;
   logic [31:0]        term_ff;
   logic [COUNT_W-1:0] count_ff;
   trig_state_t        state_ff;
   trig_state_t        nxt_state;
   logic [31:0]        cmdWord;
   logic               cmdWrite;
   logic               cmdStart;
   logic               cmdStop;
   logic               cmdForce;
   logic               extMode;
   logic               driveOut;
   logic               edgeHit;
   logic               trigEvent;
   logic               trigOut_ff;
   logic               replayStart_ff;
   logic               termEn_ff;
   logic [31:0]        statusWord;

   // the status and count registers are read only
   assign ra.wrHit = isKnownIdx(ra.wrIdx) && (ra.wrIdx != IDX_STATUS) &&
                     (ra.wrIdx != IDX_COUNT);
   assign ra.rdHit = isKnownIdx(ra.rdIdx);

   assign cmdWrite = ra.wrEn && (ra.wrIdx == IDX_COMMAND);
   assign cmdWord  = mergeBytes(command_ff, ra.wrData, ra.wrStrb);
   assign cmdStart = cmdWrite && (cmdWord == CMD_START);
   assign cmdStop  = cmdWrite && (cmdWord == CMD_STOP);
   assign cmdForce = cmdWrite && (cmdWord == CMD_FORCE);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         command_ff <= RST_WORD;
      end else if (cmdWrite) begin
         command_ff <= cmdWord;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff <= RST_MODE;
         dir_ff  <= RST_DIR;
         term_ff <= RST_WORD;
      end else if (ra.wrEn) begin
         if (ra.wrIdx == IDX_MODE) begin
            mode_ff <= mergeBytes(mode_ff, ra.wrData, ra.wrStrb);
         end
         if (ra.wrIdx == IDX_DIR) begin
            dir_ff <= mergeBytes(dir_ff, ra.wrData, ra.wrStrb);
         end
         if (ra.wrIdx == IDX_TERM) begin
            term_ff <= mergeBytes(term_ff, ra.wrData, ra.wrStrb);
         end
      end
   end

   always_comb begin
      statusWord                = RST_WORD;
      statusWord[ST_BIT_IDLE]   = (state_ff == ST_IDLE);
      statusWord[ST_BIT_ARMED]  = (state_ff == ST_ARMED);
      statusWord[ST_BIT_REPLAY] = (state_ff == ST_REPLAY);
      statusWord[ST_BIT_EXT]    = extMode;
      statusWord[ST_BIT_OE]     = driveOut;
      statusWord[ST_BIT_TERM]   = termEn_ff;
      statusWord[ST_BIT_LEVEL]  = ev.level;
   end

   always_comb begin
      case (ra.rdIdx)
         IDX_COMMAND: ra.rdData = command_ff;
         IDX_MODE:    ra.rdData = mode_ff;
         IDX_DIR:     ra.rdData = dir_ff;
         IDX_TERM:    ra.rdData = term_ff;
         IDX_STATUS:  ra.rdData = statusWord;
         IDX_COUNT:   ra.rdData = {{(32-COUNT_W){1'b0}}, count_ff};
         default:     ra.rdData = RST_WORD;
      endcase
   end

   // ****************************************************************
   // trigger decision
   // ****************************************************************
   assign extMode = isExtMode(mode_ff);

   // external modes take the connector over whatever the direction says
   assign driveOut = !extMode && (dir_ff == DIR_OUTPUT);

   always_comb begin
      case (mode_ff)
         MODE_RISING:  edgeHit = ev.rise;
         MODE_FALLING: edgeHit = ev.fall;
         MODE_EITHER:  edgeHit = ev.rise | ev.fall;
         default:      edgeHit = 1'b0;
      endcase
   end

   // only the armed state listens; replay in progress masks all edges
   assign trigEvent = (state_ff == ST_ARMED) && !cmdStop &&
                      ((mode_ff == MODE_FREE_RUN) || edgeHit || cmdForce);

   always_comb begin
      case (state_ff)
         ST_IDLE:   nxt_state = cmdStart ? ST_ARMED : ST_IDLE;
         ST_ARMED:  nxt_state = cmdStop ? ST_IDLE : (trigEvent ? ST_REPLAY : ST_ARMED);
         ST_REPLAY: nxt_state = cmdStop ? ST_IDLE : (replayDone ? ST_ARMED : ST_REPLAY);
         default:   nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_ff <= '0;
      end else if (cmdStart && (state_ff == ST_IDLE)) begin
         count_ff <= '0;
      end else if (trigEvent) begin
         count_ff <= count_ff + 1'b1;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // the pulse rises with replayStart so outside gear sees the data start
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         replayStart_ff <= 1'b0;
         trigOut_ff     <= 1'b0;
      end else begin
         replayStart_ff <= trigEvent;
         trigOut_ff     <= trigEvent && driveOut;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         termEn_ff <= 1'b0;
      end else begin
         termEn_ff <= term_ff[0] && extMode;
      end
   end

   assign trigPinOut   = trigOut_ff;
   assign trigPinOe    = driveOut;
   assign termEnable   = termEn_ff;
   assign replayStart  = replayStart_ff;
   assign boardRunning = (state_ff != ST_IDLE);

endmodule : replay_trigger_control

`default_nettype wire

// >>> dv/replay_trig_asserts.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// port checks
// ****************************************************************
module replay_trig_asserts
   import replay_trig_pkg::*;
#(
   parameter int COUNT_W = 16
)
(
   input wire logic              clk,
   input wire logic              arst_n,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic [31:0]       wdata,
   input wire logic [3:0]        wstrb,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [31:0]       rdata,
   input wire logic [1:0]        rresp,
   input wire logic              rvalid,
   input wire logic              rready,
   input wire logic              trigPinIn,
   input wire logic              trigPinOut,
   input wire logic              trigPinOe,
   input wire logic              termEnable,
   input wire logic              replayDone,
   input wire logic              replayStart,
   input wire logic              boardRunning
);
   logic inReplay_ff;

   // a stop also ends the replay, so the next start is legal
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) inReplay_ff <= 1'b0;
      else if (replayStart) inReplay_ff <= 1'b1;
      else if (replayDone || !boardRunning) inReplay_ff <= 1'b0;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_no_retrig: assert property (replayStart |-> !inReplay_ff)
      else $error("replay start while replay active");
   chk_start_single: assert property (replayStart |=> !replayStart)
      else $error("replay start longer than one cycle");
   chk_out_at_start: assert property (trigPinOut |-> replayStart && trigPinOe)
      else $error("trigger output without replay start");
   chk_start_running: assert property (replayStart |-> boardRunning)
      else $error("replay start while board idle");
   chk_oe_term_excl: assert property (trigPinOe && $past(trigPinOe) |-> !termEnable)
      else $error("termination on while connector drives");
   chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped early");
   chk_r_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_w_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
      else $error("write answer late");

endmodule : replay_trig_asserts

bind replay_trigger_control replay_trig_asserts #(.COUNT_W(COUNT_W)) u_chk (.*);

`default_nettype wire

// >>> dv/trig_source_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// external trigger source and replay engine stand-in
// ****************************************************************
module trig_source_model #(
   parameter int DONE_DLY = 6
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pinOe,
   input wire logic pinOut,
   input wire logic replayStart,
   input wire logic holdDone,
   input wire logic srcLevel,
   output logic     pinLevel,
   output logic     replayDone
);
   int cnt;
   bit busy;

   // one shared connector: whoever drives owns the level
   assign pinLevel = pinOe ? pinOut : srcLevel;

   // replay ends after a fixed time unless the bench holds it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         cnt <= 0;
         replayDone <= 1'b0;
      end else begin
         replayDone <= 1'b0;
         if (replayStart) begin
            busy <= 1'b1;
            cnt <= 0;
         end else if (busy && cnt < DONE_DLY) cnt <= cnt + 1;
         else if (busy && !holdDone) begin
            replayDone <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule : trig_source_model

`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench
   import replay_trig_pkg::*;
;
   logic              clk = 1'b0;
   logic              arst_n, awvalid, wvalid, bready, arvalid, rready, holdDone, srcLevel;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, rngState, n0, n1, d;
   logic [31:0]       starts = '0;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, r;
   logic              awready, wready, bvalid, arready, rvalid, trigPinIn, trigPinOut;
   logic              trigPinOe, termEnable, replayDone, replayStart, boardRunning, outAtStart;
   int                errCount, numChecks;
   logic [31:0]       modes [3] = '{MODE_RISING, MODE_FALLING, MODE_EITHER};

   replay_trigger_control #(.COUNT_W(16)) DUT (.*);
   trig_source_model PRT (.clk(clk), .arst_n(arst_n), .pinOe(trigPinOe), .pinOut(trigPinOut),
      .replayStart(replayStart), .holdDone(holdDone), .srcLevel(srcLevel),
      .pinLevel(trigPinIn), .replayDone(replayDone));

   always #5 clk = ~clk;

   // counted on the falling edge, clear of the launching edge
   always @(negedge clk) if (replayStart === 1'b1) begin
      starts = starts + 1;
      outAtStart = trigPinOut;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xorshift

   function automatic logic [31:0] expTrig(input logic [31:0] m, input bit rise);
      return {31'h0, (m == MODE_EITHER) || (rise ? m == MODE_RISING : m == MODE_FALLING)};
   endfunction : expTrig

   task automatic summarize();
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic chkBit(input string nm, input logic e, input logic g);
      numChecks++;
      if (g !== e) begin
         errCount++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask : chkBit

   task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chkWord

   task automatic busWr(input logic [15:0] idx, input logic [31:0] v, output logic [1:0] rs);
      int n;
      bit done;
      n = 0;
      done = 0;
      awaddr <= {idx, 2'b00};
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            done = 1;
         end
         if (++n > 50) begin
            errCount++;
            summarize();
         end
      end
   endtask : busWr

   task automatic busRd(input logic [15:0] idx, output logic [31:0] v, output logic [1:0] rs);
      int n;
      bit done;
      n = 0;
      done = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = rdata;
            rs = rresp;
            done = 1;
         end
         if (++n > 50) begin
            errCount++;
            summarize();
         end
      end
   endtask : busRd

   initial begin
      {arst_n, awvalid, wvalid, bready, arvalid, rready, holdDone, srcLevel} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      rngState = 32'h0001_7f8d;
      errCount = 0;
      numChecks = 0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      busRd(IDX_MODE, d, r); chkWord("mode reset", RST_MODE, d);
      busRd(IDX_DIR, d, r); chkWord("dir reset", RST_DIR, d);
      busRd(IDX_TERM, d, r); chkWord("term reset", RST_WORD, d);
      busRd(16'h0123, d, r); chkWord("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      busWr(IDX_STATUS, 32'h0000_0001, r); chkWord("ro resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      $display("test registers done");
      busWr(IDX_TERM, 32'h0000_0001, r);
      for (int k = 0; k < 2; k++) begin
         busWr(IDX_MODE, MODE_FREE_RUN, r);
         busWr(IDX_DIR, k == 0 ? DIR_OUTPUT : DIR_UNUSED, r);
         chkBit("oe", k == 0, trigPinOe);
         chkBit("term internal", 1'b0, termEnable);
         n0 = starts;
         busWr(IDX_COMMAND, CMD_START, r);
         repeat (28) @(posedge clk);
         chkWord("free run starts", n0 + 3, starts);
         chkBit("pin at start", k == 0, outAtStart);
         busWr(IDX_COMMAND, CMD_STOP, r);
         @(posedge clk);
         chkBit("stopped", 1'b0, boardRunning);
         $display("test free run done");
      end
      busWr(IDX_DIR, DIR_OUTPUT, r);
      holdDone <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         busWr(IDX_MODE, modes[m], r);
         chkBit("oe external", 1'b0, trigPinOe);
         srcLevel <= 1'b1;
         repeat (5) @(posedge clk);
         chkBit("term external", 1'b1, termEnable);
         n0 = starts;
         busWr(IDX_COMMAND, CMD_START, r);
         repeat (10) @(posedge clk);
         chkWord("steady level", n0, starts);
         srcLevel <= 1'b0;
         repeat (8) @(posedge clk);
         chkWord("falling edge", n0 + expTrig(modes[m], 0), starts);
         n1 = starts;
         srcLevel <= 1'b1;
         repeat (8) @(posedge clk);
         chkWord("rising edge", n1 + (expTrig(modes[m], 1) & {31'h0, n1 == n0}), starts);
         n0 = starts;
         busWr(IDX_COMMAND, CMD_FORCE, r);
         repeat (6) @(posedge clk);
         chkWord("force in replay", n0, starts);
         holdDone <= 1'b0;
         @(posedge clk);
         holdDone <= 1'b1;
         repeat (4) @(posedge clk);
         busWr(IDX_COMMAND, CMD_FORCE, r);
         repeat (6) @(posedge clk);
         chkWord("force armed", n0 + 1, starts);
         busWr(IDX_COMMAND, CMD_STOP, r);
         $display("test edge mode %0d done", m);
      end
      for (int i = 0; i < 4; i++) begin
         rngState = xorshift(rngState);
         busWr(IDX_TERM, rngState, r);
         busRd(IDX_TERM, d, r);
         chkWord("term readback", rngState, d);
         repeat (2) @(posedge clk);
         chkBit("term follows", rngState[0], termEnable);
      end
      $display("test random termination done");
      summarize();
   end
endmodule : testbench

`default_nettype wire
